// File: rtl/orp_pkg.sv
// Function
// - 256-byte internal RAM answers in page 0 and page 1 alike, except at page 0 addresses 0000 and 0001.
// - Address 0001 selects the port output register; writes update output pins.
// - Address 0000 selects the port direction register.
// - Each direction bit sets its own pin's direction independently.
// - Address bus can be released to three-state for other bus masters.
// - Address driven only while drive-enable input high; others drive when low.
// - Read/write output high except during write cycles.
package orp_pkg;
   localparam logic [15:0] ORP_DIR_ADDR   = 16'h0000;
   localparam logic [15:0] ORP_OUT_ADDR   = 16'h0001;
   localparam logic [7:0]  ORP_DIR_RESET  = 8'h00;
   localparam logic [7:0]  ORP_OUT_RESET  = 8'h00;
   localparam logic [6:0]  ORP_RAM_PAGES  = 7'h00;
   localparam int          ORP_RAM_WORDS  = 256;
endpackage

// File: rtl/orp_ram.sv
`timescale 1ns/10ps
module orp_ram
   import orp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       we,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   output logic      [7:0] rdata
);
   logic [7:0] mem [ORP_RAM_WORDS];

   // Read is combinational so the port logic can register the answer
   // itself and keep every top-level output on a flip-flop
   assign rdata = mem[addr];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
   end
endmodule

// File: rtl/orp_top.sv
`timescale 1ns/10ps
module orp_top
   import orp_pkg::*;
(
   input  wire logic        SYS_CLK,
   input  wire logic        RST,
   input  wire logic [15:0] CPU_ADDR,
   input  wire logic        CPU_VALID,
   input  wire logic        CPU_WRITE,
   input  wire logic [7:0]  CPU_WDATA,
   output logic      [7:0]  CPU_RDATA,
   output logic             CPU_RVALID,
   output logic             CPU_HIT,
   input  wire logic        ADDRESS_BUS_DRIVE_ENABLE,
   output logic      [15:0] ADDR_O,
   output logic      [15:0] ADDR_OE,
   output logic             RD_WR_N,
   input  wire logic [7:0]  PORT_PINS_I,
   output logic      [7:0]  PORT_PINS_O,
   output logic      [7:0]  PORT_PINS_OE
);
   import orp_pkg::*;

   typedef enum logic [1:0] {
      ORP_RD_NONE = 2'b00,
      ORP_RD_DIR  = 2'b01,
      ORP_RD_OUT  = 2'b11,
      ORP_RD_RAM  = 2'b10
   } orp_rsel_t;

   logic [7:0]  dir_q,  dir_d;
   logic [7:0]  outr_q, outr_d;
   orp_rsel_t   rsel_d;
   logic [15:0] addr_q;
   logic [15:0] oe_q;
   logic        rw_q;
   logic        rvalid_q;
   logic        hit_q;
   logic [7:0]  rdata_q;
   logic [7:0]  rdata_d;
   logic [7:0]  pins_o_q;
   logic [7:0]  ram_rdata;

   function automatic logic is_ram_page(input logic [15:0] a);
      return a[15:9] == ORP_RAM_PAGES;
   endfunction

   wire logic sel_dir = CPU_VALID && (CPU_ADDR == ORP_DIR_ADDR);
   wire logic sel_out = CPU_VALID && (CPU_ADDR == ORP_OUT_ADDR);
   // Port registers shadow the bottom two RAM bytes of page 0 only;
   // page 1 offsets 0 and 1 stay ordinary RAM.
   wire logic sel_ram = CPU_VALID && is_ram_page(CPU_ADDR)
                        && !sel_dir && !sel_out;
   wire logic ram_we  = sel_ram && CPU_WRITE;
   wire logic [7:0] pin_view = (PORT_PINS_I & ~dir_q)
                               | (outr_q & dir_q);

   assign dir_d  = (sel_dir && CPU_WRITE) ? CPU_WDATA : dir_q;
   assign outr_d = (sel_out && CPU_WRITE) ? CPU_WDATA : outr_q;
   assign rsel_d = (CPU_VALID && !CPU_WRITE) ?
                   (sel_dir ? ORP_RD_DIR :
                    sel_out ? ORP_RD_OUT :
                    sel_ram ? ORP_RD_RAM : ORP_RD_NONE) : ORP_RD_NONE;

   orp_ram u_ram (
      .clk   (SYS_CLK),
      .we    (ram_we),
      .addr  (CPU_ADDR[7:0]),
      .wdata (CPU_WDATA),
      .rdata (ram_rdata)
   );

   // Read data is chosen at the request edge and registered, so the
   // answer lands one cycle later with pins sampled at the request
   assign rdata_d = (rsel_d == ORP_RD_DIR) ? dir_q     :
                    (rsel_d == ORP_RD_OUT) ? pin_view  :
                    (rsel_d == ORP_RD_RAM) ? ram_rdata : 8'h00;

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         dir_q    <= ORP_DIR_RESET;
         outr_q   <= ORP_OUT_RESET;
         pins_o_q <= ORP_OUT_RESET & ORP_DIR_RESET;
         addr_q   <= 16'h0000;
         oe_q     <= 16'h0000;
         rw_q     <= 1'b1;
         rvalid_q <= 1'b0;
         hit_q    <= 1'b0;
         rdata_q  <= 8'h00;
      end else begin
         dir_q    <= dir_d;
         outr_q   <= outr_d;
         pins_o_q <= outr_d & dir_d;
         addr_q   <= CPU_ADDR;
         oe_q     <= {16{ADDRESS_BUS_DRIVE_ENABLE}};
         rw_q     <= !(CPU_VALID && CPU_WRITE);
         rvalid_q <= CPU_VALID && !CPU_WRITE;
         hit_q    <= sel_dir || sel_out || sel_ram;
         rdata_q  <= rdata_d;
      end
   end

   assign CPU_RDATA    = rdata_q;
   assign CPU_RVALID   = rvalid_q;
   assign CPU_HIT      = hit_q;
   assign ADDR_O       = addr_q;
   assign ADDR_OE      = oe_q;
   assign RD_WR_N      = rw_q;
   assign PORT_PINS_O  = pins_o_q;
   assign PORT_PINS_OE = dir_q;

   property p_addr_release;
      @(posedge SYS_CLK) disable iff (RST)
      !ADDRESS_BUS_DRIVE_ENABLE |=> (ADDR_OE == 16'h0000);
   endproperty
   a_addr_release: assert property (p_addr_release)
      else $error("address bus driven while drive enable low");

   property p_addr_drive;
      @(posedge SYS_CLK) disable iff (RST)
      ADDRESS_BUS_DRIVE_ENABLE |=> (ADDR_OE == 16'hFFFF);
   endproperty
   a_addr_drive: assert property (p_addr_drive)
      else $error("address bus not driven while enable high");

   property p_rw_high;
      @(posedge SYS_CLK) disable iff (RST)
      !(CPU_VALID && CPU_WRITE) |=> RD_WR_N;
   endproperty
   a_rw_high: assert property (p_rw_high)
      else $error("read/write low outside a write");

   property p_rw_low;
      @(posedge SYS_CLK) disable iff (RST)
      (CPU_VALID && CPU_WRITE) |=> !RD_WR_N;
   endproperty
   a_rw_low: assert property (p_rw_low)
      else $error("read/write high during a write");

   property p_dir_write;
      @(posedge SYS_CLK) disable iff (RST)
      (CPU_VALID && CPU_WRITE && CPU_ADDR == ORP_DIR_ADDR)
      |=> (PORT_PINS_OE == $past(CPU_WDATA));
   endproperty
   a_dir_write: assert property (p_dir_write)
      else $error("direction write not applied");

   property p_out_write;
      @(posedge SYS_CLK) disable iff (RST)
      (CPU_VALID && CPU_WRITE && CPU_ADDR == ORP_OUT_ADDR)
      |=> (PORT_PINS_O == ($past(CPU_WDATA) & PORT_PINS_OE));
   endproperty
   a_out_write: assert property (p_out_write)
      else $error("output write not on pins");

   property p_in_undriven;
      @(posedge SYS_CLK) disable iff (RST)
      (PORT_PINS_O & ~PORT_PINS_OE) == 8'h00;
   endproperty
   a_in_undriven: assert property (p_in_undriven)
      else $error("input pin carries drive value");

   sequence s_port_read;
      CPU_VALID && !CPU_WRITE && CPU_ADDR == ORP_OUT_ADDR;
   endsequence
   property p_port_read;
      @(posedge SYS_CLK) disable iff (RST)
      s_port_read |=> CPU_RVALID
         && ((CPU_RDATA & ~dir_q) == ($past(PORT_PINS_I) & ~dir_q));
   endproperty
   a_port_read: assert property (p_port_read)
      else $error("port read does not show input pins");

   sequence s_ram_wr;
      CPU_VALID && CPU_WRITE && CPU_ADDR == 16'h0180;
   endsequence
   sequence s_ram_rd_alias;
      CPU_VALID && !CPU_WRITE && CPU_ADDR == 16'h0080;
   endsequence
   property p_page_alias;
      @(posedge SYS_CLK) disable iff (RST)
      s_ram_wr ##1 s_ram_rd_alias |=> (CPU_RDATA == $past(CPU_WDATA, 2));
   endproperty
   a_page_alias: assert property (p_page_alias)
      else $error("page 1 write not seen in page 0");

   sequence s_mapped_req;
      CPU_VALID && is_ram_page(CPU_ADDR);
   endsequence
   property p_mapped_hit;
      @(posedge SYS_CLK) disable iff (RST)
      s_mapped_req |=> CPU_HIT;
   endproperty
   a_mapped_hit: assert property (p_mapped_hit)
      else $error("mapped access did not hit");

   property p_unmapped_miss;
      @(posedge SYS_CLK) disable iff (RST)
      (CPU_VALID && !is_ram_page(CPU_ADDR)) |=> !CPU_HIT;
   endproperty
   a_unmapped_miss: assert property (p_unmapped_miss)
      else $error("unmapped access reported a hit");

   property p_addr_follow;
      @(posedge SYS_CLK) disable iff (RST)
      ADDRESS_BUS_DRIVE_ENABLE |=> (ADDR_O == $past(CPU_ADDR));
   endproperty
   a_addr_follow: assert property (p_addr_follow)
      else $error("driven address does not follow the core");

   property p_dir_hold;
      @(posedge SYS_CLK) disable iff (RST)
      !(CPU_VALID && CPU_WRITE && CPU_ADDR == ORP_DIR_ADDR)
      |=> $stable(PORT_PINS_OE);
   endproperty
   a_dir_hold: assert property (p_dir_hold)
      else $error("direction changed without a direction write");

   sequence s_dir_read;
      CPU_VALID && !CPU_WRITE && CPU_ADDR == ORP_DIR_ADDR;
   endsequence
   property p_dir_read;
      @(posedge SYS_CLK) disable iff (RST)
      s_dir_read |=> CPU_RVALID && (CPU_RDATA == $past(PORT_PINS_OE));
   endproperty
   a_dir_read: assert property (p_dir_read)
      else $error("direction read returned a wrong value");

   property p_out_read;
      @(posedge SYS_CLK) disable iff (RST)
      s_port_read
      |=> (CPU_RDATA & $past(PORT_PINS_OE)) == $past(PORT_PINS_O);
   endproperty
   a_out_read: assert property (p_out_read)
      else $error("port read does not show output bits");
endmodule

// File: verif/orp_periph.sv
`timescale 1ns/10ps
module orp_periph (
   input  wire logic [7:0] oe,
   input  wire logic [7:0] dout,
   input  wire logic [7:0] drv,
   output logic      [7:0] pins
);
   // Peripheral drives only the bits that the port leaves undriven
   assign pins = (oe & dout) | (~oe & drv);
endmodule

// File: verif/onchip_ram_and_io_port_decode_tb.sv
`timescale 1ns/10ps
module onchip_ram_and_io_port_decode_tb;
   import orp_pkg::*;
   logic        clk = 0;
   logic        rst = 1;
   logic [15:0] addr = 16'h0000;
   logic        vld = 0;
   logic        wr = 0;
   logic [7:0]  wd = 8'h00;
   logic        aen = 0;
   logic [7:0]  drv = 8'h3C;
   logic [7:0]  pins, po, poe, rd;
   logic [15:0] ao, aoe;
   logic        rv, hit, rwn;
   int          err_total = 0;
   int          comparisons = 0;
   always #4 clk = ~clk;
   orp_top dut (.SYS_CLK(clk), .RST(rst), .CPU_ADDR(addr),
      .CPU_VALID(vld), .CPU_WRITE(wr), .CPU_WDATA(wd), .CPU_RDATA(rd),
      .CPU_RVALID(rv), .CPU_HIT(hit), .ADDRESS_BUS_DRIVE_ENABLE(aen),
      .ADDR_O(ao), .ADDR_OE(aoe), .RD_WR_N(rwn), .PORT_PINS_I(pins),
      .PORT_PINS_O(po), .PORT_PINS_OE(poe));
   orp_periph per (.oe(poe), .dout(po), .drv(drv), .pins(pins));
   task chk(input logic [15:0] s, input logic [15:0] e);
      comparisons++;
      if (s !== e) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // Requests go back to back; valid stays up between them
   task acc(input logic w, input logic [15:0] a, input logic [7:0] d,
            input logic [7:0] e);
      vld = 1;
      wr = w;
      addr = a;
      wd = d;
      @(posedge clk);
      #1;
      chk(16'(hit), 16'(a < 16'h0200));
      chk(16'(rwn), 16'(!w));
      chk(16'(rv), 16'(!w));
      if (!w)
         chk(16'(rd), 16'(e));
   endtask
   task give_verdict;
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      #1;
      rst = 0;
      chk(16'(poe), 16'h0000);
      chk(16'(rwn), 16'h0001);
      chk(aoe, 16'h0000);
      acc(1, ORP_DIR_ADDR, 8'h0F, 8'h00);
      chk(16'(poe), 16'h000F);
      acc(1, ORP_OUT_ADDR, 8'hA5, 8'h00);
      chk(16'(po), 16'h0005);
      acc(0, ORP_OUT_ADDR, 8'h00, 8'h35);
      acc(0, ORP_DIR_ADDR, 8'h00, 8'h0F);
      acc(1, 16'h0102, 8'h77, 8'h00);
      acc(0, 16'h0002, 8'h00, 8'h77);
      acc(1, 16'h00FF, 8'h12, 8'h00);
      acc(0, 16'h01FF, 8'h00, 8'h12);
      acc(1, 16'h0180, 8'h5A, 8'h00);
      acc(0, 16'h0080, 8'h00, 8'h5A);
      acc(1, 16'h0100, 8'h9A, 8'h00);
      acc(0, ORP_DIR_ADDR, 8'h00, 8'h0F);
      acc(0, 16'h0100, 8'h00, 8'h9A);
      acc(1, 16'h0200, 8'h55, 8'h00);
      acc(0, 16'h0200, 8'h00, 8'h00);
      acc(1, ORP_DIR_ADDR, 8'hF0, 8'h00);
      acc(0, ORP_DIR_ADDR, 8'h00, 8'hF0);
      chk(16'(po), 16'h00A0);
      acc(0, ORP_OUT_ADDR, 8'h00, 8'hAC);
      vld = 0;
      aen = 1;
      addr = 16'h1234;
      @(posedge clk);
      #1;
      chk(aoe, 16'hFFFF);
      chk(ao, 16'h1234);
      aen = 0;
      @(posedge clk);
      #1;
      chk(aoe, 16'h0000);
      // Mid-run reset: port goes back to all inputs, RAM keeps its bytes
      rst = 1;
      @(posedge clk);
      #1;
      chk(16'(poe), 16'h0000);
      chk(16'(po), 16'h0000);
      chk(16'(rwn), 16'h0001);
      chk(aoe, 16'h0000);
      rst = 0;
      acc(0, 16'h0100, 8'h00, 8'h9A);
      acc(0, ORP_DIR_ADDR, 8'h00, 8'h00);
      give_verdict;
   end
endmodule
